// ==== logic/lrs_crc.sv ====
`timescale 1ns/1ps
module lrs_crc
  import lrs_pkg::*;
(
  input wire logic clk_sys,    // system clock
  input wire logic srst_n,     // synchronised reset, active low
  lrs_crc_if.gen   crc_if      // byte feed and result
);
  logic [15:0] crc_q, crc_d, sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [7:0]  buf_q, buf_d;
  logic        pend_q, pend_d;

  // one bit into the generator, feedback from stage 16
  function automatic logic [15:0] step(input logic [15:0] c, input logic b);
    logic fb;
    fb = c[15] ^ b;
    return {c[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_CLEAR); // R5
  endfunction

  // one bit per cycle; a byte lasts 64 cycles on the wire, so this keeps up
  always_comb
  begin
    crc_d  = crc_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    buf_d  = buf_q;
    pend_d = pend_q;
    if (crc_if.start)
    begin
      crc_d  = CRC_CLEAR;   // R6
      sh_d   = CRC_PRELOAD; // R6
      cnt_d  = CRC_PRE_LEN;
      pend_d = 1'b0;
    end
    else if (cnt_q != 5'h00)
    begin
      crc_d = step(crc_q, sh_q[15]); // R21
      sh_d  = {sh_q[14:0], 1'b0};
      cnt_d = cnt_q - 5'h01;
    end
    else if (pend_q)
    begin
      sh_d   = {buf_q, 8'h00}; // R7
      cnt_d  = CRC_BYTE;
      pend_d = 1'b0;
    end
    if (crc_if.load)
    begin
      buf_d  = crc_if.data;
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge srst_n)
  begin
    if (!srst_n)
    begin
      crc_q  <= CRC_CLEAR;
      sh_q   <= CRC_CLEAR;
      cnt_q  <= 5'h00;
      buf_q  <= 8'h00;
      pend_q <= 1'b0;
    end
    else
    begin
      crc_q  <= crc_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      buf_q  <= buf_d;
      pend_q <= pend_d;
    end
  end

  assign crc_if.crc  = crc_q;
  assign crc_if.busy = pend_q || (cnt_q != 5'h00);

  a_crc_preload: assert property (@(posedge clk_sys) disable iff (!srst_n) // R6
    crc_if.start |=> crc_q == CRC_CLEAR ##16 crc_q == CRC_EMPTY)
    else $error("preload of all ones did not give the empty-frame value");
  a_crc_poly_step: assert property (@(posedge clk_sys) disable iff (!srst_n) // R5
    (cnt_q != 5'h00 && !crc_if.start && crc_q[15] == sh_q[15])
      |=> crc_q == {$past(crc_q[14:0]), 1'b0})
    else $error("generator fed back without a feedback bit");
endmodule

// ==== logic/lrs_crc_if.sv ====
`timescale 1ns/1ps
interface lrs_crc_if;
  logic        start; // clear and preload
  logic        load;  // one frame byte
  logic [7:0]  data;
  logic [15:0] crc;
  logic        busy;
  modport eng (output start, load, data, input crc, busy);
  modport gen (input start, load, data, output crc, busy);
endinterface

// ==== logic/lrs_pkg.sv ====
package lrs_pkg;
  // first control byte of each command
  localparam logic [7:0] CMD_WAKE     = 8'hC3;
  localparam logic [7:0] CMD_SLEEP    = 8'hC6;
  localparam logic [7:0] CMD_TP_ODD   = 8'hE8;
  localparam logic [7:0] CMD_TP_EVEN  = 8'hE4;
  localparam logic [7:0] CMD_TP_ALL   = 8'hE2;
  localparam logic [7:0] CMD_TP_CLR   = 8'hE1;
  localparam logic [7:0] CMD_RESET    = 8'hF0;
  localparam logic [7:0] CMD_INTEG    = 8'hB8;
  localparam logic [7:0] CMD_WRITE_TH = 8'hD2;
  localparam logic [7:0] CMD_READOUT  = 8'h99;
  // checksum generator
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_CLEAR   = 16'h0000;
  localparam logic [15:0] CRC_PRELOAD = 16'hFFFF;
  localparam logic [15:0] CRC_EMPTY   = 16'h1D0F;
  localparam logic [4:0]  CRC_PRE_LEN = 5'h10;
  localparam logic [4:0]  CRC_BYTE    = 5'h08;
  // frame layout
  localparam int          FRAME_LEN_DEF = 16;
  localparam logic [7:0]  SANITY_DEF    = 8'h5A; // arbitrary value
  localparam logic [15:0] THR_RST       = 16'h0000;
  localparam logic [7:0]  IDX_TEMP      = 8'h06;
  localparam logic [7:0]  IDX_PIX0      = 8'h09;
  // timing: the system clock, a 1 us tick, and the sequencing delays
  localparam int CLK_MHZ    = 10;
  localparam int TICK_NS    = 1000;
  localparam int TICK_CYC   = TICK_NS * CLK_MHZ / 1000;
  localparam int T_FR_US    = 200;
  localparam int T_WAKE_US  = 500;
  localparam int T_ZEBRA_US = 100;
  localparam int FR_TICKS   = (T_FR_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int WAKE_TICKS = (T_WAKE_US * 1000) / TICK_NS;
  localparam int ZEB_TICKS  = (T_ZEBRA_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int FR_CYC     = FR_TICKS * TICK_CYC;

  typedef enum logic [3:0] {K_NONE, K_WAKE, K_SLEEP, K_RESET, K_INTEG, K_THR, K_READ,
                            K_TP_CLR, K_TP_ODD, K_TP_EVEN, K_TP_ALL} lrs_cmd_t;
  typedef enum logic [2:0] {S_POR, S_IDLE, S_INTEG, S_CONV, S_READY, S_SLEEP,
                            S_WAKING} lrs_state_t;

  // three control bytes to a command kind; fixed commands other than chip reset need zero tails
  function automatic lrs_cmd_t lrs_decode(input logic [23:0] c);
    lrs_cmd_t k;
    logic     z;
    k = K_NONE;
    z = (c[15:0] == 16'h0000);
    if (c[23:16] == CMD_RESET) k = K_RESET;
    else if (c[23:16] == CMD_INTEG) k = K_INTEG;
    else if (c[23:16] == CMD_WRITE_TH) k = K_THR;
    else if (c[23:16] == CMD_READOUT) k = K_READ;
    else if (z && c[23:16] == CMD_WAKE) k = K_WAKE;
    else if (z && c[23:16] == CMD_SLEEP) k = K_SLEEP;
    else if (z && c[23:16] == CMD_TP_CLR) k = K_TP_CLR;
    else if (z && c[23:16] == CMD_TP_ODD) k = K_TP_ODD;
    else if (z && c[23:16] == CMD_TP_EVEN) k = K_TP_EVEN;
    else if (z && c[23:16] == CMD_TP_ALL) k = K_TP_ALL;
    return k;
  endfunction
endpackage

// ==== logic/lrs_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1: wake command C3 00 00 brings the device out of sleep.
// R2: host waits up to the wake interval before expecting full operation.
// R3: chip reset accepted in any state, sleep recovery timing applies.
// R4: 16-bit checksum over bytes up to N-2, sent as last two bytes.
// R5: checksum polynomial has terms sixteen, twelve, five and zero.
// R6: generator cleared to zero, then all ones shifted in before data.
// R7: frame bytes shifted in frame order, average byte last.
// R8: first checksum byte is stages 16..9, second stages 8..1.
// R9: host checks whole frame gives zero, else discards it.
// R10: temperature conversion result placed in frame byte 6.
// R11: host sends chip reset as its first command.
// R12: after integration wait the frame-ready delay, then raise frame-done.
// R13: host starts new integration only after read-out completes.
// R14: host writes thresholds before starting integration.
// R15: first scan after power-on or chip reset is a dummy.
// R16: test patterns replace start-integration; read-out after frame-done.
// R17: frame-done is a dedicated output usable as an interrupt.
// R18: four-wire serial interface: select, clock, data in, data out.
// R19: sleep command C6 00 00 shuts oscillator and converter down.
// R20: test-pattern integration starts when select returns high.
// R21: checksum bytes shifted most significant bit first.
module lrs_top
  import lrs_pkg::*;
#(
  parameter int         FRAME_LEN = FRAME_LEN_DEF, // frame bytes incl. checksum
  parameter logic [7:0] SANITY    = SANITY_DEF     // first frame byte
)(
  input  wire logic        clk_sys,    // 10 MHz system clock
  input  wire logic        nrst,       // reset, active low
  input  wire logic        cs_n,       // serial select, active low
  input  wire logic        sclk,       // serial clock from host
  input  wire logic        mosi,       // serial data from host
  output      logic        miso,       // serial data to host
  output      logic        frame_done, // frame ready for read-out
  output      logic        osc_en,     // oscillator running
  output      logic        adc_en,     // converter powered
  output      logic        integ_on,   // pixel integration active
  output      logic        tp_on,      // test pattern in use
  output      logic [1:0]  tp_sel,     // 0 cleared, 1 odd, 2 even, 3 all
  output      logic [15:0] thr,        // low-resolution thresholds
  output      logic        temp_conv,  // temperature conversion request
  input  wire logic [7:0]  temp_code,  // temperature converter result
  output      logic        pix_next,   // pixel byte taken
  input  wire logic [7:0]  pixel_byte, // current pixel byte
  input  wire logic [7:0]  avg_byte    // pixel average byte
);
  logic [1:0] rsync_q;
  logic       srst_n;
  logic [2:0] s1_q, s2_q, s3_q;
  logic       cs_s, sclk_rise, cs_rise, cs_fall, mosi_s;

  // reset released through two flops
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst) rsync_q <= 2'b00;
    else rsync_q <= {rsync_q[0], 1'b1};
  end
  assign srst_n = rsync_q[1];

  // pins pass two flops; a third copy only finds edges
  always_ff @(posedge clk_sys or negedge srst_n)
  begin
    if (!srst_n)
    begin
      s1_q <= 3'h1;
      s2_q <= 3'h1;
      s3_q <= 3'h1;
    end
    else
    begin
      s1_q <= {mosi, sclk, cs_n}; // R18
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign cs_s      = s2_q[0];
  assign mosi_s    = s2_q[2];
  assign sclk_rise = s2_q[1] && !s3_q[1] && !cs_s;
  assign cs_rise   = cs_s && !s3_q[0];
  assign cs_fall   = !cs_s && s3_q[0];

  lrs_crc_if crc_if ();

  lrs_crc u_crc (
    .clk_sys (clk_sys),
    .srst_n  (srst_n),
    .crc_if  (crc_if)
  );

  // serial datapath state
  logic [7:0]  rx_q, rx_d, tx_q, tx_d, bcnt_q, bcnt_d, fidx, fb, rxb;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  cmd_q [3];
  logic [7:0]  cmd_d [3];
  logic        byte_done, ro_start, ld, pixn_d, tconv_d, pixn_q, tconv_q;
  // sequencing state
  lrs_state_t  st_q, st_d;
  lrs_cmd_t    kind;
  logic [15:0] tmr_q, tmr_d, thr_q, thr_d;
  logic [7:0]  prev_q [3];
  logic [7:0]  prev_d [3];
  logic [7:0]  fcnt_q, fcnt_d;
  logic [3:0]  tick_q, tick_d;
  logic        tick, rd_q, rd_d, dummy_q, dummy_d, tpon_q, tpon_d, exec;
  logic [1:0]  tps_q, tps_d;

  assign rxb       = {rx_q[6:0], mosi_s};
  assign byte_done = sclk_rise && (bit_q == 3'h7);
  assign fidx      = bcnt_q - 8'h02;
  // the read-out command starts streaming as soon as its third byte lands
  assign ro_start  = byte_done && bcnt_q == 8'h02 && st_q == S_READY && !rd_q
                     && lrs_decode({cmd_q[0], cmd_q[1], rxb}) == K_READ;
  assign ld        = byte_done && (ro_start || rd_q) && bcnt_q >= 8'h02;
  assign exec      = cs_rise && bcnt_q == 8'h03 && !rd_q;
  assign kind      = lrs_decode({cmd_q[0], cmd_q[1], cmd_q[2]});

  // frame byte by index
  always_comb
  begin
    fb = pixel_byte;
    if (fidx >= 8'(FRAME_LEN)) fb = 8'h00;
    else if (fidx == 8'(FRAME_LEN - 1)) fb = crc_if.crc[7:0];  // R8
    else if (fidx == 8'(FRAME_LEN - 2)) fb = crc_if.crc[15:8]; // R8
    else if (fidx == 8'(FRAME_LEN - 3)) fb = avg_byte;
    else if (fidx == 8'h00) fb = SANITY;
    else if (fidx <= 8'h03) fb = prev_q[2'(fidx - 8'h01)];
    else if (fidx <= 8'h05) fb = cmd_q[2'(fidx - 8'h03)];
    else if (fidx == IDX_TEMP) fb = temp_code;                 // R10
    else if (fidx == 8'h07) fb = {dummy_q, tpon_q, tps_q, 4'h0};
    else if (fidx == 8'h08) fb = fcnt_q;
  end

  // checksum feed: every byte before the two checksum bytes
  assign crc_if.start = ro_start;                                    // R6
  assign crc_if.load  = ld && fidx <= 8'(FRAME_LEN - 3);             // R4
  assign crc_if.data  = fb;                                          // R7

  // receive and send one bit per serial clock rise; the outgoing bit moves
  // right after the rise, a full half period before the host samples again
  always_comb
  begin
    rx_d    = rx_q;
    tx_d    = tx_q;
    bit_d   = bit_q;
    bcnt_d  = bcnt_q;
    cmd_d   = cmd_q;
    pixn_d  = 1'b0;
    tconv_d = ro_start;
    if (cs_fall)
    begin
      bit_d  = 3'h0;
      bcnt_d = 8'h00;
      tx_d   = 8'h00;
    end
    else if (sclk_rise)
    begin
      rx_d  = rxb;
      tx_d  = {tx_q[6:0], 1'b0}; // R21
      bit_d = bit_q + 3'h1;
      if (byte_done)
      begin
        if (bcnt_q < 8'h03) cmd_d[bcnt_q[1:0]] = rxb;
        if (bcnt_q != 8'hFF) bcnt_d = bcnt_q + 8'h01;
        if (ld)
        begin
          tx_d   = fb;
          pixn_d = fidx >= IDX_PIX0 && fidx < 8'(FRAME_LEN - 3);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge srst_n)
  begin
    if (!srst_n)
    begin
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      bit_q   <= 3'h0;
      bcnt_q  <= 8'h00;
      cmd_q   <= '{8'h00, 8'h00, 8'h00};
      pixn_q  <= 1'b0;
      tconv_q <= 1'b0;
    end
    else
    begin
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      bit_q   <= bit_d;
      bcnt_q  <= bcnt_d;
      cmd_q   <= cmd_d;
      pixn_q  <= pixn_d;
      tconv_q <= tconv_d;
    end
  end

  // 1 us tick from a divider; all sequencing delays count ticks
  assign tick = (tick_q == 4'(TICK_CYC - 1));

  // sequencer; a delay ends on the tick after the timer hits zero, so the
  // full programmed number of tick periods always elapses
  always_comb
  begin
    st_d    = st_q;
    tmr_d   = tmr_q;
    thr_d   = thr_q;
    prev_d  = prev_q;
    fcnt_d  = fcnt_q;
    rd_d    = rd_q;
    dummy_d = dummy_q;
    tpon_d  = tpon_q;
    tps_d   = tps_q;
    tick_d  = tick ? 4'h0 : tick_q + 4'h1;
    if (tick && tmr_q != 16'h0000) tmr_d = tmr_q - 16'h0001;
    unique case (st_q)
      S_INTEG:  if (tick && tmr_q == 16'h0000)
                begin
                  st_d  = S_CONV;
                  tmr_d = 16'(FR_TICKS); // R12
                end
      S_CONV:   if (tick && tmr_q == 16'h0000) st_d = S_READY; // R12
      S_WAKING: if (tick && tmr_q == 16'h0000) st_d = S_IDLE;
      S_POR, S_IDLE, S_READY, S_SLEEP: ;
    endcase
    if (ro_start) rd_d = 1'b1;
    if (cs_rise && rd_q)
    begin
      // read-out over: a new integration may start now
      rd_d    = 1'b0;
      st_d    = S_IDLE;
      fcnt_d  = fcnt_q + 8'h01;
      dummy_d = 1'b0;
      prev_d  = cmd_q;
    end
    if (exec && (st_q != S_POR || kind == K_RESET)
        && (st_q != S_SLEEP || kind == K_RESET || kind == K_WAKE))
    begin
      if (kind != K_NONE && kind != K_READ) prev_d = cmd_q;
      unique case (kind)
        K_RESET:
        begin
          st_d    = (st_q == S_SLEEP) ? S_WAKING : S_IDLE; // R3
          tmr_d   = 16'(WAKE_TICKS);
          thr_d   = THR_RST;
          fcnt_d  = 8'h00;
          dummy_d = 1'b1;
          tpon_d  = 1'b0;
          prev_d  = '{8'h00, 8'h00, 8'h00};
        end
        K_WAKE:
          if (st_q == S_SLEEP)
          begin
            st_d  = S_WAKING; // R1
            tmr_d = 16'(WAKE_TICKS);
          end
        K_SLEEP: st_d = S_SLEEP; // R19
        K_THR:
          if (st_q == S_IDLE || st_q == S_READY) thr_d = {cmd_q[1], cmd_q[2]};
        K_INTEG:
          if (st_q == S_IDLE || st_q == S_READY)
          begin
            st_d   = S_INTEG;
            tmr_d  = {cmd_q[1], cmd_q[2]};
            tpon_d = 1'b0;
          end
        K_TP_CLR, K_TP_ODD, K_TP_EVEN, K_TP_ALL:
          if (st_q == S_IDLE || st_q == S_READY)
          begin
            st_d   = S_INTEG; // R20
            tmr_d  = 16'(ZEB_TICKS);
            tpon_d = 1'b1;    // R16
            tps_d  = (kind == K_TP_CLR) ? 2'h0 : (kind == K_TP_ODD) ? 2'h1 :
                     (kind == K_TP_EVEN) ? 2'h2 : 2'h3;
          end
        K_READ, K_NONE: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge srst_n)
  begin
    if (!srst_n)
    begin
      st_q    <= S_POR;
      tmr_q   <= 16'h0000;
      thr_q   <= THR_RST;
      prev_q  <= '{8'h00, 8'h00, 8'h00};
      fcnt_q  <= 8'h00;
      tick_q  <= 4'h0;
      rd_q    <= 1'b0;
      dummy_q <= 1'b1;
      tpon_q  <= 1'b0;
      tps_q   <= 2'h0;
    end
    else
    begin
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      thr_q   <= thr_d;
      prev_q  <= prev_d;
      fcnt_q  <= fcnt_d;
      tick_q  <= tick_d;
      rd_q    <= rd_d;
      dummy_q <= dummy_d;
      tpon_q  <= tpon_d;
      tps_q   <= tps_d;
    end
  end

  // outputs: state decodes and flops
  assign miso       = tx_q[7];                    // R18
  assign frame_done = (st_q == S_READY) && !rd_q; // R17
  assign osc_en     = (st_q != S_SLEEP);          // R19
  assign adc_en     = (st_q != S_SLEEP);          // R19
  assign integ_on   = (st_q == S_INTEG);
  assign tp_on      = tpon_q;
  assign tp_sel     = tps_q;
  assign thr        = thr_q;
  assign temp_conv  = tconv_q;
  assign pix_next   = pixn_q;

  // cycles spent converting, for the frame-ready delay check
  int conv_cnt_q;
  always_ff @(posedge clk_sys or negedge srst_n)
  begin
    if (!srst_n) conv_cnt_q <= 0;
    else conv_cnt_q <= (st_q == S_CONV) ? conv_cnt_q + 1 : 0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!srst_n);

  a_wake_from_sleep: assert property ( // R1
    exec && st_q == S_SLEEP && kind == K_WAKE |=> st_q == S_WAKING ##1 !osc_en == 1'b0)
    else $error("wake command did not leave sleep");
  a_reset_any_state: assert property ( // R3
    exec && kind == K_RESET |=> (st_q == S_IDLE || st_q == S_WAKING) && dummy_q)
    else $error("chip reset not taken");
  a_crc_first_byte: assert property ( // R8
    ld && fidx == 8'(FRAME_LEN - 2) |=> tx_q == $past(crc_if.crc[15:8]) && miso == tx_q[7])
    else $error("first checksum byte is not stages 16..9");
  a_crc_second_byte: assert property ( // R4
    ld && fidx == 8'(FRAME_LEN - 1) |=> tx_q == $past(crc_if.crc[7:0]) && !crc_if.busy)
    else $error("second checksum byte wrong or generator still busy");
  a_temp_in_frame: assert property ( // R10
    ld && fidx == IDX_TEMP |=> tx_q == $past(temp_code))
    else $error("temperature byte missing at byte 6");
  a_ready_delay: assert property ( // R12
    $rose(frame_done) && $past(st_q) == S_CONV |-> conv_cnt_q >= FR_CYC)
    else $error("frame-done raised before the frame-ready delay");
  a_integ_on_cs: assert property ( // R20
    $rose(integ_on) |-> $past(cs_rise) && $past(bcnt_q) == 8'h03)
    else $error("integration began without select going high");
  a_sleep_stops_osc: assert property ( // R19
    exec && kind == K_SLEEP && st_q == S_IDLE |=> (!osc_en && !adc_en) [*2])
    else $error("sleep left oscillator or converter running");
  a_done_clears: assert property ( // R17
    ro_start |=> !frame_done && temp_conv ##1 !temp_conv)
    else $error("frame-done did not drop at read-out start");

  c_wake: cover property (st_q == S_WAKING ##1 st_q == S_IDLE);
  c_readout: cover property (ro_start ##[1:1000] (ld && fidx == 8'(FRAME_LEN - 1)));
  c_pattern: cover property (tpon_q && $rose(frame_done));
endmodule

// ==== sim/lrs_host.sv ====
`timescale 1ns/1ps
// host side of the link: mode 0 master, clock parked low between frames
module lrs_host
  import lrs_pkg::*;
#(
  parameter int LEN = 16 // frame bytes incl. checksum
)(
  input  wire logic clk_sys, // bench clock
  output      logic cs_n,    // select, active low
  output      logic sclk,    // serial clock
  output      logic mosi,    // host data
  input  wire logic miso     // device data
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // every change lands 1 ns after a clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // four clocks a phase keeps each level above the device's sampling floor
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      wait_clk(4);
      sclk = 1'b1;
      rx[i] = miso; // taken at the rising edge, before the device moves it
      wait_clk(4);
      sclk = 1'b0;
    end
  endtask

  task automatic cmd_bytes(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
    logic [7:0] d;
    cs_n = 1'b0;
    wait_clk(4);
    xfer(c1, d);
    xfer(c2, d);
    xfer(c3, d);
  endtask

  // released data line shows the inverse so no stale bit can be relied on
  task automatic desel();
    wait_clk(4);
    cs_n = 1'b1;
    mosi = ~mosi;
    wait_clk(8);
  endtask

  task automatic cmd(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
    cmd_bytes(c1, c2, c3);
    desel();
  endtask

  task automatic readout(input logic [7:0] c2, input logic [7:0] c3, output logic [7:0] f [LEN]);
    cmd_bytes(CMD_READOUT, c2, c3);
    for (int k = 0; k < LEN; k++)
      xfer(8'h00, f[k]);
    desel();
  endtask
endmodule

// ==== sim/test_lrs_top.sv ====
`timescale 1ns/1ps
module test_lrs_top;
  import lrs_pkg::*;
  localparam int LEN   = FRAME_LEN_DEF;
  localparam int LIMIT = 60000; // about one and a half times the expected run
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic        cs_n, sclk, mosi, miso, frame_done, osc_en, adc_en;
  logic        integ_on, tp_on, temp_conv, pix_next;
  logic [1:0]  tp_sel;
  logic [15:0] thr;
  logic [15:0] thr_exp    = 16'h0000;
  logic [7:0]  temp_code  = 8'h3C;
  logic [7:0]  pixel_byte = 8'h10;
  logic [7:0]  avg_byte   = 8'h77;
  logic [7:0]  fc_q       = 8'h00;
  int          failures   = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          conv_cnt   = 0;

  always #50 clk_sys = ~clk_sys;

  lrs_top #(.FRAME_LEN(LEN), .SANITY(SANITY_DEF)) u_lrs_top (
    .clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .frame_done(frame_done), .osc_en(osc_en), .adc_en(adc_en), .integ_on(integ_on),
    .tp_on(tp_on), .tp_sel(tp_sel), .thr(thr), .temp_conv(temp_conv),
    .temp_code(temp_code), .pix_next(pix_next), .pixel_byte(pixel_byte), .avg_byte(avg_byte));

  lrs_host #(.LEN(LEN)) u_lrs_host (
    .clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

  // pixel source steps on each pixel taken; watchdog on cycles
  // pulses are read 1 ns after the edge, once the flops have settled
  always @(posedge clk_sys)
  begin
    #1;
    cyc++;
    if (temp_conv === 1'b1) conv_cnt++;
    if (pix_next === 1'b1) pixel_byte = pixel_byte + 8'h01;
    if (cyc == LIMIT)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // bench's own reference: direct shift register, msb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic t_por();
    check(thr, THR_RST, "threshold reset value");
    u_lrs_host.cmd(CMD_INTEG, 8'h00, 8'h05);
    u_lrs_host.wait_clk(20);
    check(integ_on, 1'b0, "integrate taken before chip reset");
    u_lrs_host.cmd(CMD_RESET, 8'h00, 8'h00);
    u_lrs_host.wait_clk(20);
    check(frame_done, 1'b0, "frame done after chip reset");
  endtask

  // start one scan, time the frame ready flag, read and judge the frame
  task automatic t_scan(input logic [7:0] c1, input logic [7:0] c3, input int us,
                        input logic dmy, input logic tpon, input logic [1:0] tsel);
    logic [7:0]  f [LEN];
    logic [7:0]  e [LEN];
    logic [15:0] c;
    logic [7:0]  pix;
    logic        ran;
    int          n;
    int          conv0;
    temp_code = temp_code + 8'h11;
    u_lrs_host.cmd_bytes(c1, 8'h00, c3);
    u_lrs_host.wait_clk(40);
    check(integ_on, 1'b0, "integration before select released");
    u_lrs_host.desel();
    n = 8;
    ran = 1'b0;
    while (frame_done !== 1'b1 && n < 5000)
    begin
      u_lrs_host.wait_clk(1);
      n++;
      if (integ_on === 1'b1) ran = 1'b1;
    end
    check(ran, 1'b1, "integration ran");
    check(n >= (us + FR_TICKS) * TICK_CYC, 1'b1, "frame ready early");
    check(n <= (us + FR_TICKS + 2) * TICK_CYC + 10, 1'b1, "frame ready late");
    check({tp_on, tp_sel}, {tpon, tsel}, "pattern select");
    pix = pixel_byte;
    conv0 = conv_cnt;
    u_lrs_host.readout(8'h02, 8'h8F, f);
    e[0] = SANITY_DEF;
    e[1] = c1;
    e[2] = 8'h00;
    e[3] = c3;
    e[4] = 8'h02;
    e[5] = 8'h8F;
    e[6] = temp_code;
    e[7] = {dmy, tpon, tsel, 4'h0};
    e[8] = dmy ? 8'h00 : fc_q + 8'h01; // chip reset restarts the frame count
    for (int k = 9; k <= LEN - 4; k++)
      e[k] = pix + 8'(k - 9);
    e[LEN-3] = avg_byte;
    c = crc_step(crc_step(CRC_CLEAR, 8'hFF), 8'hFF);
    for (int k = 0; k <= LEN - 3; k++)
      c = crc_step(c, e[k]);
    e[LEN-2] = c[15:8];
    e[LEN-1] = c[7:0];
    for (int k = 0; k < LEN; k++)
      check(f[k], e[k], "frame byte");
    c = crc_step(crc_step(CRC_CLEAR, 8'hFF), 8'hFF);
    for (int k = 0; k < LEN; k++)
      c = crc_step(c, f[k]);
    check(c, 16'h0000, "whole frame checksum");
    check(16'(conv_cnt - conv0), 16'h0001, "temperature conversions");
    check(frame_done, 1'b0, "frame done after read-out");
    fc_q = f[8];
  endtask

  // sleep, refuse work, leave by wake or by chip reset
  task automatic t_sleep(input logic by_reset);
    u_lrs_host.cmd(CMD_SLEEP, 8'h00, 8'h00);
    check({osc_en, adc_en}, 2'b00, "sleep powers down");
    u_lrs_host.cmd(CMD_WRITE_TH, 8'hA5, 8'h5A);
    check(thr, thr_exp, "threshold taken in sleep");
    u_lrs_host.cmd(by_reset ? CMD_RESET : CMD_WAKE, 8'h00, 8'h00);
    u_lrs_host.wait_clk((WAKE_TICKS + 2) * TICK_CYC);
    check({osc_en, adc_en}, 2'b11, "awake");
    thr_exp = {8'h12, 7'h1A, by_reset};
    u_lrs_host.cmd(CMD_WRITE_TH, thr_exp[15:8], thr_exp[7:0]);
    check(thr, thr_exp, "threshold after wake");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    #1 nrst = 1'b1;
    u_lrs_host.wait_clk(8);
    t_por();
    t_scan(CMD_INTEG, 8'h05, 5, 1'b1, 1'b0, 2'd0);
    t_scan(CMD_TP_ODD, 8'h00, T_ZEBRA_US, 1'b0, 1'b1, 2'd1);
    t_scan(CMD_TP_EVEN, 8'h00, T_ZEBRA_US, 1'b0, 1'b1, 2'd2);
    t_scan(CMD_TP_ALL, 8'h00, T_ZEBRA_US, 1'b0, 1'b1, 2'd3);
    t_scan(CMD_TP_CLR, 8'h00, T_ZEBRA_US, 1'b0, 1'b1, 2'd0);
    t_scan(CMD_INTEG, 8'h03, 3, 1'b0, 1'b0, 2'd0);
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_scan(CMD_INTEG, 8'h02, 2, 1'b1, 1'b0, 2'd0);
    end_of_test();
  end
endmodule
